// >>> rtl/swd_regs.svh
// register map, reset values and timing counts of the watchdog set
`ifndef SWD_REGS_SVH
`define SWD_REGS_SVH
// Notes on behaviour
// - three watchdogs: two main, one RTC-domain
// - flash boot auto-enables RTC and first main
// - four stages, own timeouts, 32-bit counter
// - each stage enabled or disabled alone
// - main expiry: interrupt, CPU or core reset
// - RTC expiry: adds system reset option
// - locked configuration writes are ignored
// - late flash boot reboots main system
// - CPU reset hits one chosen core only
// - core reset spares RTC, system reset not

// bank decode: address[6:5] picks a watchdog, 3 is global
`define SWD_GLOBAL_BANK 2'h3
`define SWD_RTC_BANK    2'h2
// word index inside a bank, address[4:2]
`define SWD_CFG_OFS  3'h0
`define SWD_TMO0_OFS 3'h1
`define SWD_FEED_OFS 3'h5
`define SWD_KEY_OFS  3'h6
`define SWD_STAT_OFS 3'h7
`define SWD_GCTL_OFS 3'h0
// configuration word fields
`define SWD_CFG_EN_BIT  0
`define SWD_CFG_CPU_BIT 1
`define SWD_CFG_SEN_LSB 4
`define SWD_CFG_ACT_LSB 8
`define SWD_CFG_ACT_GAP 4
// reset values
`define SWD_TMO_RST  32'hFFFF_FFFF
`define SWD_LOCK_RST 1'b1
// key value is arbitrary
`define SWD_UNLOCK_KEY 32'h5A5A_A5A5
// timing
`define SWD_CLK_HZ   10000000
`define SWD_BOOT_MS  1000
`define SWD_AUTO_MS  2000
`define SWD_BOOT_CYC (`SWD_BOOT_MS * (`SWD_CLK_HZ / 1000))
`define SWD_AUTO_CYC (`SWD_AUTO_MS * (`SWD_CLK_HZ / 1000))
`endif

// >>> rtl/swd_pkg.sv
// types shared by the staged watchdog set
package swd_pkg;
  // expiry action of one stage
  typedef enum logic [2:0] {
    ACT_OFF  = 3'h0,
    ACT_IRQ  = 3'h1,
    ACT_CPU  = 3'h2,
    ACT_CORE = 3'h3,
    ACT_SYS  = 3'h4
  } swd_act_t;
  // stage sequence, gray coded along 0-1-2-3
  typedef enum logic [1:0] {
    STG_0 = 2'h0,
    STG_1 = 2'h1,
    STG_2 = 2'h3,
    STG_3 = 2'h2
  } swd_stage_t;
  // configuration of one watchdog
  typedef struct packed {
    logic [3:0][31:0] tmo;
    swd_act_t [3:0]   act;
    logic [3:0]       stg_en;
    logic             cpu_sel;
    logic             en;
  } swd_cfg_t;
  // events of one watchdog
  typedef struct packed {
    logic       irq;
    logic [1:0] cpu_rst;
    logic       core_rst;
    logic       sys_rst;
  } swd_evt_t;
  // stage to index
  function automatic logic [1:0] swd_idx(input swd_stage_t s);
    return {s[1], s[1] ^ s[0]};
  endfunction
  // index to stage
  function automatic swd_stage_t swd_stg(input logic [1:0] i);
    return swd_stage_t'({i[1], i[1] ^ i[0]});
  endfunction
endpackage

// >>> rtl/swd_core.sv
// one four-stage watchdog engine
`timescale 1ns/1ps
`default_nettype none
`include "swd_regs.svh"
module swd_core
  import swd_pkg::*;
#(
  parameter bit IS_RTC = 1'b0
)
(
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  // control
  input  wire swd_cfg_t   cfg,
  input  wire logic       feed,
  input  wire logic       clr,
  // state and events
  output var  swd_stage_t stage,
  output var  swd_evt_t   evt
);
  logic [31:0] cnt_r;  // expiry counter
  logic [1:0]  idx;    // current stage as index
  logic        any_en; // some stage enabled
  logic        hit;    // enabled stage expires
  logic        skip;   // disabled stage passed over

  assign idx    = swd_idx(stage);
  assign any_en = cfg.en && (|cfg.stg_en);
  assign hit    = any_en && cfg.stg_en[idx] && (cnt_r >= cfg.tmo[idx]);
  assign skip   = any_en && !cfg.stg_en[idx];

  // stage walk and counter
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      stage <= STG_0;
      cnt_r <= 32'h0;
    end
    else if (ce)
    begin
      if (feed || clr || !cfg.en)
      begin
        // feed returns to the first stage
        stage <= STG_0;
        cnt_r <= 32'h0;
      end
      else if (hit || skip)
      begin
        // next stage counts from zero
        stage <= swd_stg(idx + 2'h1);
        cnt_r <= 32'h0;
      end
      else if (any_en)
        cnt_r <= cnt_r + 32'h1;
    end
  end

  // expiry actions; resets pulse, interrupt holds until fed
  always_ff @(posedge mclk)
  begin
    if (srst)
      evt <= '0;
    else if (ce)
    begin
      evt.cpu_rst  <= 2'h0;
      evt.core_rst <= 1'b0;
      evt.sys_rst  <= 1'b0;
      if (feed || clr || !cfg.en)
        evt.irq <= 1'b0;
      else if (hit)
      begin
        case (cfg.act[idx])
          ACT_IRQ:  evt.irq <= 1'b1;
          ACT_CPU:  evt.cpu_rst[cfg.cpu_sel] <= 1'b1;
          ACT_CORE: evt.core_rst <= 1'b1;
          ACT_SYS:
          begin
            // main watchdogs cannot reach the RTC domain
            evt.core_rst <= 1'b1;
            evt.sys_rst  <= IS_RTC;
          end
          default:  evt.irq <= evt.irq;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/swd_bootguard.sv
// flash boot guard: auto-enable and boot deadline
`timescale 1ns/1ps
`default_nettype none
`include "swd_regs.svh"
module swd_bootguard
#(
  parameter logic [31:0] BOOT_CYC = `SWD_BOOT_CYC
)
(
  // clock, reset, enable
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic ce,
  // boot status
  input  wire logic flash_boot,
  input  wire logic boot_done,
  // results
  output logic      auto_en,
  output logic      guard_on,
  output logic      expire
);
  logic        seen_r; // strap already sampled
  logic [31:0] cnt_r;  // boot time so far

  // strap caught in the first cycle after release
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      seen_r   <= 1'b0;
      guard_on <= 1'b0;
      auto_en  <= 1'b0;
      expire   <= 1'b0;
      cnt_r    <= 32'h0;
    end
    else if (ce)
    begin
      auto_en <= 1'b0;
      expire  <= 1'b0;
      if (!seen_r)
      begin
        seen_r   <= 1'b1;
        guard_on <= flash_boot;
        auto_en  <= flash_boot;
      end
      else if (guard_on)
      begin
        if (boot_done)
          guard_on <= 1'b0;
        else if (cnt_r >= BOOT_CYC - 32'h1)
        begin
          // deadline missed, reboot main system
          expire   <= 1'b1;
          guard_on <= 1'b0;
        end
        else
          cnt_r <= cnt_r + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/swd_top.sv
// staged watchdog set with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "swd_regs.svh"
module swd_top
  import swd_pkg::*;
#(
  parameter logic [31:0] BOOT_CYC = `SWD_BOOT_CYC,
  parameter logic [31:0] AUTO_CYC = `SWD_AUTO_CYC
)
(
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ce,
  // avalon-mm slave
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // boot strap
  input  wire logic        flash_boot,
  // watchdog outputs
  output logic [2:0]       wdt_irq,
  output logic [1:0]       cpu_rst,
  output logic             core_rst,
  output logic             sys_rst
);
  //--------------------------------------------------
  // declarations
  //--------------------------------------------------
  swd_cfg_t    cfg_r [3];   // per watchdog configuration
  logic [2:0]  lock_r;      // write protection per watchdog
  logic [2:0]  feed_r;      // feed pulse per watchdog
  logic        done_r;      // software says boot is done
  swd_evt_t    evt [3];     // events from the engines
  swd_stage_t  stg [3];     // current stages
  logic        auto_en;     // boot auto-enable pulse
  logic        guard_on;    // boot deadline running
  logic        boot_exp;    // boot deadline missed
  logic [1:0]  bank;        // selected watchdog
  logic [2:0]  word;        // selected word
  logic        wr;          // write takes effect now
  logic [31:0] rd_nxt;      // read data to latch
  logic [1:0]  any_cpu;     // combined cpu resets
  logic        any_core;    // combined core resets
  logic        any_sys;     // combined system resets

  assign bank = avs_address[6:5];
  assign word = avs_address[4:2];
  // the write lands on the edge where waitrequest is low
  assign wr   = avs_write && !avs_waitrequest;

  //--------------------------------------------------
  // helpers
  //--------------------------------------------------
  // pack configuration fields into the bus word
  function automatic logic [31:0] cfg_word(input swd_cfg_t c);
    logic [31:0] w;
    w = 32'h0;
    w[`SWD_CFG_EN_BIT]  = c.en;
    w[`SWD_CFG_CPU_BIT] = c.cpu_sel;
    w[`SWD_CFG_SEN_LSB +: 4] = c.stg_en;
    for (int k = 0; k < 4; k++)
      w[`SWD_CFG_ACT_LSB + `SWD_CFG_ACT_GAP * k +: 3] = c.act[k];
    return w;
  endfunction

  // replace only the enabled byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] w;
    w = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        w[8 * b +: 8] = nw[8 * b +: 8];
    return w;
  endfunction

  //--------------------------------------------------
  // bus handshake
  //--------------------------------------------------
  // every access waits exactly one cycle, then is answered
  always_ff @(posedge mclk)
  begin
    if (srst)
      avs_waitrequest <= 1'b1;
    else if (ce)
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end

  // read data latched one edge before waitrequest is seen low
  always_ff @(posedge mclk)
  begin
    if (srst)
      avs_readdata <= 32'h0;
    else if (ce && avs_read && avs_waitrequest)
      avs_readdata <= rd_nxt;
  end

  //--------------------------------------------------
  // read decode
  //--------------------------------------------------
  always_comb
  begin
    rd_nxt = 32'h0;
    if (bank == `SWD_GLOBAL_BANK)
    begin
      // global status: boot done and guard running
      if (word == `SWD_GCTL_OFS)
        rd_nxt = {30'h0, guard_on, done_r};
    end
    else if (word == `SWD_CFG_OFS)
      rd_nxt = cfg_word(cfg_r[bank]);
    else if (word == `SWD_FEED_OFS)
      rd_nxt = 32'h0; // feed reads as zero
    else if (word == `SWD_KEY_OFS)
      rd_nxt = {31'h0, lock_r[bank]};
    else if (word == `SWD_STAT_OFS)
      rd_nxt = {29'h0, evt[bank].irq, swd_idx(stg[bank])};
    else
      rd_nxt = cfg_r[bank].tmo[2'(word - `SWD_TMO0_OFS)];
  end

  //--------------------------------------------------
  // configuration registers
  //--------------------------------------------------
  // auto-enable on flash boot, else guarded software writes
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cfg_r[i]     <= '0;
        cfg_r[i].tmo <= {4{`SWD_TMO_RST}};
      end
    end
    else if (ce)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (auto_en && (i != 1))
        begin
          // first main and RTC watchdog armed without software
          cfg_r[i].en     <= 1'b1;
          cfg_r[i].stg_en <= 4'h1;
          cfg_r[i].tmo[0] <= AUTO_CYC;
          cfg_r[i].act[0] <= (i == 2) ? ACT_SYS : ACT_CORE;
        end
        else if (wr && (bank == 2'(i)) && !lock_r[i])
        begin
          if (word == `SWD_CFG_OFS)
          begin
            logic [31:0] w;
            w = merge(cfg_word(cfg_r[i]), avs_writedata,
                      avs_byteenable);
            cfg_r[i].en      <= w[`SWD_CFG_EN_BIT];
            cfg_r[i].cpu_sel <= w[`SWD_CFG_CPU_BIT];
            cfg_r[i].stg_en  <= w[`SWD_CFG_SEN_LSB +: 4];
            for (int k = 0; k < 4; k++)
              cfg_r[i].act[k] <= swd_act_t'(
                w[`SWD_CFG_ACT_LSB + `SWD_CFG_ACT_GAP * k +: 3]);
          end
          else if ((word >= `SWD_TMO0_OFS) && (word < `SWD_FEED_OFS))
          begin
            // one timeout word per stage
            cfg_r[i].tmo[2'(word - `SWD_TMO0_OFS)] <= merge(
              cfg_r[i].tmo[2'(word - `SWD_TMO0_OFS)],
              avs_writedata, avs_byteenable);
          end
        end
      end
    end
  end

  //--------------------------------------------------
  // write protection
  //--------------------------------------------------
  // only the full key unlocks, any other key write relocks
  always_ff @(posedge mclk)
  begin
    if (srst)
      lock_r <= {3{`SWD_LOCK_RST}};
    else if (ce)
    begin
      for (int i = 0; i < 3; i++)
        if (wr && (bank == 2'(i)) && (word == `SWD_KEY_OFS))
          lock_r[i] <= !((avs_byteenable == 4'hF) &&
                         (avs_writedata == `SWD_UNLOCK_KEY));
    end
  end

  //--------------------------------------------------
  // feed and boot done
  //--------------------------------------------------
  // feed is a one-cycle pulse, dropped while locked
  always_ff @(posedge mclk)
  begin
    if (srst)
      feed_r <= 3'h0;
    else if (ce)
    begin
      for (int i = 0; i < 3; i++)
        feed_r[i] <= wr && (bank == 2'(i)) &&
                     (word == `SWD_FEED_OFS) && !lock_r[i];
    end
  end

  // write one to bit 0 ends the boot deadline
  always_ff @(posedge mclk)
  begin
    if (srst)
      done_r <= 1'b0;
    else if (ce && wr && (bank == `SWD_GLOBAL_BANK) &&
             (word == `SWD_GCTL_OFS) && avs_byteenable[0] &&
             avs_writedata[0])
      done_r <= 1'b1;
  end

  //--------------------------------------------------
  // engines
  //--------------------------------------------------
  // two main watchdogs and one RTC-domain watchdog
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_wdt
      swd_core #(
        .IS_RTC (g == 2)
      ) u_core (
        .mclk  (mclk),
        .srst  (srst),
        .ce    (ce),
        .cfg   (cfg_r[g]),
        .feed  (feed_r[g]),
        // a core reset spares the RTC-domain watchdog
        .clr   ((g == 2) ? sys_rst : (core_rst || sys_rst)),
        .stage (stg[g]),
        .evt   (evt[g])
      );
    end
  endgenerate

  swd_bootguard #(
    .BOOT_CYC (BOOT_CYC)
  ) u_guard (
    .mclk       (mclk),
    .srst       (srst),
    .ce         (ce),
    .flash_boot (flash_boot),
    .boot_done  (done_r),
    .auto_en    (auto_en),
    .guard_on   (guard_on),
    .expire     (boot_exp)
  );

  //--------------------------------------------------
  // reset and interrupt outputs
  //--------------------------------------------------
  // merge the events of all three watchdogs
  always_comb
  begin
    any_cpu  = 2'h0;
    any_core = boot_exp;
    any_sys  = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      any_cpu  = any_cpu | evt[i].cpu_rst;
      any_core = any_core | evt[i].core_rst;
      any_sys  = any_sys | evt[i].sys_rst;
    end
  end

  // outputs registered once more for clean pins
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wdt_irq  <= 3'h0;
      cpu_rst  <= 2'h0;
      core_rst <= 1'b0;
      sys_rst  <= 1'b0;
    end
    else if (ce)
    begin
      for (int i = 0; i < 3; i++)
        wdt_irq[i] <= evt[i].irq;
      cpu_rst  <= any_cpu;
      core_rst <= any_core;
      sys_rst  <= any_sys;
    end
  end
endmodule
`default_nettype wire

// >>> sim/swd_chk_sva.sv
// port checker of the staged watchdog set
`timescale 1ns/1ps
`default_nettype none
module swd_chk
(
  // clock, reset, enable
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        ce,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // watchdog outputs
  input wire logic [2:0]  wdt_irq,
  input wire logic [1:0]  cpu_rst,
  input wire logic        core_rst,
  input wire logic        sys_rst
);
  // ----------------------------------------
  // bus handshake steps
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // a fresh request while clock enabled
  sequence s_req;
    ce && $rose(avs_read || avs_write);
  endsequence
  // one-cycle acknowledge
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus answer not one cycle after request");
  a_ack_req: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("acknowledge without request");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  a_reset_clean: assert property ($fell(srst) |-> avs_waitrequest &&
    wdt_irq == 3'h0 && cpu_rst == 2'h0 && !core_rst && !sys_rst)
    else $error("outputs not quiet after reset");
  // ----------------------------------------
  // reset and interrupt outputs
  // ----------------------------------------
  a_sys_core: assert property (sys_rst |-> core_rst)
    else $error("system reset without core reset");
  a_core_pulse: assert property (core_rst |=> !core_rst)
    else $error("core reset longer than one cycle");
  a_cpu_one: assert property (|cpu_rst |->
    $onehot(cpu_rst) ##1 !cpu_rst)
    else $error("cpu reset not one core for one cycle");
  // irq only drops after a bus write or a domain clear
  a_irq_hold: assert property (wdt_irq[0] && !avs_write &&
    !$past(avs_write) && !$past(avs_write, 2) && !core_rst &&
    !$past(core_rst) |=> wdt_irq[0])
    else $error("interrupt dropped by itself");
endmodule
bind swd_top swd_chk u_chk
(
  .mclk            (mclk),
  .srst            (srst),
  .ce              (ce),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .wdt_irq         (wdt_irq),
  .cpu_rst         (cpu_rst),
  .core_rst        (core_rst),
  .sys_rst         (sys_rst)
);
`default_nettype wire

// >>> sim/tb_top.sv
// register-level testbench of the staged watchdog set
`timescale 1ns/1ps
`default_nettype none
`include "swd_regs.svh"
module tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        flash_boot = 1'b0;
  logic [6:0]  avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  wdt_irq;
  logic [1:0]  cpu_rst;
  logic        core_rst;
  logic        sys_rst;
  logic [31:0] rd_v;
  logic [3:0]  ev;
  int          fails = 0;
  int          compares = 0;
  int          n;
  // action table: bank, config word, expected {cpu_rst, core, sys}
  logic [1:0]  t_b [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
  logic [31:0] t_c [5] = '{32'h213, 32'h311, 32'h411, 32'h411, 32'h211};
  logic [3:0]  t_e [5] = '{4'h8, 4'h2, 4'h2, 4'h3, 4'h4};
  // short counts keep the boot tests fast
  swd_top #(.BOOT_CYC(32'h32), .AUTO_CYC(32'h64)) u_swd_top
  (
    .mclk(mclk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_boot(flash_boot), .wdt_irq(wdt_irq), .cpu_rst(cpu_rst),
    .core_rst(core_rst), .sys_rst(sys_rst)
  );
  always #50 mclk = ~mclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // bank and word are cut to their field widths on purpose
  function automatic logic [6:0] adr(input int b, input int w);
    return {b[1:0], w[2:0], 2'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      fails++;
    end
  endtask
  // one avalon access; request held until waitrequest seen low
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    // waitrequest and read data are taken at the same rising edge
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 40);
    check({31'h0, avs_waitrequest}, 32'h0);
    rd_v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // unlock, set stage 0 timeout, write config
  task automatic arm(input int b, input logic [31:0] c,
                     input logic [31:0] t);
    bus(1'b1, adr(b, 3'h6), `SWD_UNLOCK_KEY, 4'hF);
    bus(1'b1, adr(b, 3'h1), t, 4'hF);
    bus(1'b1, adr(b, 3'h0), c, 4'hF);
  endtask
  // first reset pulse within a bounded span
  task automatic wait_evt(input int max);
    ev = 4'h0;
    for (int k = 0; k < max && ev == 4'h0; k++)
    begin
      @(negedge mclk);
      ev = {cpu_rst, core_rst, sys_rst};
    end
  endtask
  task automatic do_reset(input logic fb);
    @(posedge mclk);
    srst <= 1'b1;
    flash_boot <= fb;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    // boot arming lands two edges after release, let it settle
    repeat (2) @(posedge mclk);
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    do_reset(1'b0);
    for (int b = 0; b < 3; b++)
    begin
      bus(1'b0, adr(b, 3'h0), 32'h0, 4'hF);
      check(rd_v, 32'h0);
      for (int w = 1; w < 5; w++)
      begin
        bus(1'b0, adr(b, w), 32'h0, 4'hF);
        check(rd_v, `SWD_TMO_RST);
      end
      bus(1'b0, adr(b, 3'h6), 32'h0, 4'hF);
      check(rd_v, 32'h1);
    end
    $display("test reset values done");
    bus(1'b1, adr(0, 3'h0), 32'h11, 4'hF);
    bus(1'b0, adr(0, 3'h0), 32'h0, 4'hF);
    check(rd_v, 32'h0);
    bus(1'b1, adr(1, 3'h6), `SWD_UNLOCK_KEY, 4'hF);
    bus(1'b1, adr(1, 3'h2), 32'h1234_5678, 4'h1);
    bus(1'b1, adr(1, 3'h6), 32'h0, 4'hF);
    bus(1'b1, adr(1, 3'h2), 32'h0, 4'hF);
    bus(1'b0, adr(1, 3'h2), 32'h0, 4'hF);
    check(rd_v, 32'hFFFF_FF78);
    bus(1'b0, adr(3, 3'h1), 32'h0, 4'hF);
    check(rd_v, 32'h0);
    $display("test write lock done");
    // stages 0 and 2 enabled, irq on stage 0, stage 1 skipped
    for (int b = 0; b < 3; b++)
    begin
      arm(b, 32'h151, 32'h8);
      for (n = 0; n < 30 && wdt_irq == 3'h0; n++)
        @(negedge mclk);
      check(wdt_irq, 3'h1 << b);
      bus(1'b0, adr(b, 3'h7), 32'h0, 4'hF);
      check(rd_v, 32'h6);
      bus(1'b1, adr(b, 3'h5), 32'h0, 4'hF);
      bus(1'b0, adr(b, 3'h7), 32'h0, 4'hF);
      check(rd_v, 32'h0);
      check(wdt_irq, 3'h0);
      bus(1'b1, adr(b, 3'h0), 32'h0, 4'hF);
    end
    $display("test stages done");
    for (int i = 0; i < 5; i++)
    begin
      arm(t_b[i], t_c[i], 32'h2);
      wait_evt(30);
      check(ev, t_e[i]);
      bus(1'b1, adr(t_b[i], 3'h6), `SWD_UNLOCK_KEY, 4'hF);
      bus(1'b1, adr(t_b[i], 3'h0), 32'h0, 4'hF);
      repeat (10) @(posedge mclk);
    end
    $display("test actions done");
    // clock enable low must freeze the counter well past its timeout
    arm(1, 32'h111, 32'h8);
    ce <= 1'b0;
    repeat (40) @(posedge mclk);
    check(wdt_irq, 3'h0);
    ce <= 1'b1;
    for (n = 0; n < 30 && wdt_irq == 3'h0; n++)
      @(negedge mclk);
    check(wdt_irq, 3'h2);
    bus(1'b1, adr(1, 3'h0), 32'h0, 4'hF);
    $display("test clock enable done");
    // flash boot with no boot-done: deadline, then rtc expiry
    do_reset(1'b1);
    bus(1'b0, adr(0, 3'h0), 32'h0, 4'hF);
    check(rd_v, 32'h311);
    bus(1'b0, adr(2, 3'h0), 32'h0, 4'hF);
    check(rd_v, 32'h411);
    bus(1'b0, adr(0, 3'h1), 32'h0, 4'hF);
    check(rd_v, 32'h64);
    bus(1'b0, adr(3, 3'h0), 32'h0, 4'hF);
    check(rd_v, 32'h2);
    wait_evt(60);
    check(ev, 4'h2);
    wait_evt(120);
    check(ev, 4'h3);
    // boot done in time: no deadline reset
    do_reset(1'b1);
    bus(1'b1, adr(3, 3'h0), 32'h1, 4'hF);
    bus(1'b0, adr(3, 3'h0), 32'h0, 4'hF);
    check(rd_v, 32'h1);
    wait_evt(60);
    check(ev, 4'h0);
    $display("test flash boot done");
    results();
  end
  // hang guard, far beyond the several hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("unexpected at %0t: run timed out", $time);
    results();
  end
endmodule
`default_nettype wire
